// File: logic/mswr_top.sv
// mswr_top: per-motor status words and hex status reply
`timescale 1ns/100ps
`default_nettype none
module mswr_top #(
  parameter int POS_W = 24,
  parameter int SCAN_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // servo side conditions and events
  input wire mswr_pkg::mswr_cond_t cond,
  input wire mswr_pkg::mswr_evt_t evt,
  input wire logic signed [POS_W-1:0] actual_pos,
  input wire logic signed [POS_W-1:0] positive_soft_limit,
  input wire logic signed [POS_W-1:0] negative_soft_limit,
  input wire logic [POS_W-1:0] fe_mag,
  input wire logic [POS_W-1:0] warning_error_limit,
  input wire logic [POS_W-1:0] in_position_band,
  input wire logic [SCAN_W-1:0] in_position_scan_count,
  // overtravel pins
  input wire logic overtravel_input_a,
  input wire logic overtravel_input_b,
  // status query and reply
  input wire logic query,
  output logic query_ready,
  output logic [7:0] tx_char,
  output logic tx_valid,
  input wire logic tx_ready,
  // status registers
  output logic [23:0] motor_status_word_one,
  output logic [23:0] motor_status_word_two
);
  if (POS_W < 2 || SCAN_W < 1 || SCAN_W > 16) begin : g_chk
    $error("mswr_top: unsupported POS_W or SCAN_W");
  end

  // pin synchronisers
  logic ota_s1_q, ota_s2_q, otb_s1_q, otb_s2_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      ota_s1_q <= 1'b0;
      ota_s2_q <= 1'b0;
      otb_s1_q <= 1'b0;
      otb_s2_q <= 1'b0;
    end else begin
      ota_s1_q <= overtravel_input_a;
      ota_s2_q <= ota_s1_q;
      otb_s1_q <= overtravel_input_b;
      otb_s2_q <= otb_s1_q;
    end
  end

  // latched flags
  logic neg_lim_q, neg_lim_d, pos_lim_q, pos_lim_d;
  logic db_err_q, db_err_d, abort_dec_q, abort_dec_d;
  logic search_q, search_d, stop_lim_q, stop_lim_d;
  logic homing_q, homing_d, home_done_q, home_done_d;
  logic phase_err_q, phase_err_d, trig_q, trig_d, trig_seen_q, trig_seen_d;
  logic ffe_q, ffe_d, iffe_q, iffe_d, afault_q, afault_d, i2t_q, i2t_d;
  logic [SCAN_W:0] ip_cnt_q, ip_cnt_d;
  logic updating, ip_cond, ip_ok, warn;

  // limit checks only update while active and enabled; the overtravel
  // inputs are wired crosswise, a trips the negative end
  assign updating = cond.motor_activation_setting && cond.amp_enabled;
  assign ip_cond = !cond.loop_open && cond.cmd_vel_zero && !cond.timer_active &&
                   (fe_mag < in_position_band);
  assign ip_ok = (ip_cnt_q == ({1'b0, in_position_scan_count} + 1'b1));
  assign warn = (fe_mag > warning_error_limit) || ffe_q;

  // flag next values; in every flag except trig_seen_q a set in the clearing cycle wins
  always_comb begin
    neg_lim_d = neg_lim_q;
    pos_lim_d = pos_lim_q;
    if (updating) begin
      neg_lim_d = (actual_pos < negative_soft_limit) || ota_s2_q;
      pos_lim_d = (actual_pos > positive_soft_limit) || otb_s2_q;
    end
    db_err_d = evt.block_abort || (db_err_q && !evt.seq_start);
    abort_dec_d = evt.abort_cmd || evt.limit_stop ||
                  (abort_dec_q && !evt.decel_done);
    search_d = evt.search_start ||
               (search_q && !evt.trigger_found && !evt.move_stopped);
    // leaving the limit starts a new move, which drops the latch
    stop_lim_d = evt.limit_stop || (stop_lim_q && !evt.seq_start && !evt.reenable);
    homing_d = evt.homing_start || (homing_q && !evt.trigger_found && !evt.move_stopped);
    home_done_d = home_done_q;
    if (evt.homing_start) begin
      home_done_d = 1'b0;
    end
    if (homing_q && evt.trigger_found) begin
      home_done_d = 1'b1;
    end
    phase_err_d = evt.phase_done ? evt.phase_fail : phase_err_q;
    trig_seen_d = !evt.trig_move_start && (trig_seen_q || evt.trigger_found);
    trig_d = trig_q;
    if (evt.move_end && (trig_seen_q || evt.trigger_found)) begin
      trig_d = 1'b0;
    end
    if (evt.trig_move_start) begin
      trig_d = 1'b1;
    end
    ffe_d = evt.fatal_fe_kill || evt.int_fe_kill || (ffe_q && !evt.reenable);
    iffe_d = evt.int_fe_kill || (iffe_q && !evt.reenable);
    afault_d = evt.amp_fault_kill || evt.integrated_current_fault ||
               (afault_q && !evt.reenable);
    i2t_d = evt.integrated_current_fault || (i2t_q && !evt.reenable);
    // scan counter saturates at count plus one
    ip_cnt_d = ip_cnt_q;
    if (!ip_cond) begin
      ip_cnt_d = '0;
    end else if (evt.scan_tick && !ip_ok) begin
      ip_cnt_d = ip_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      neg_lim_q <= 1'b0;
      pos_lim_q <= 1'b0;
      db_err_q <= 1'b0;
      abort_dec_q <= 1'b0;
      search_q <= 1'b0;
      stop_lim_q <= 1'b0;
      homing_q <= 1'b0;
      home_done_q <= 1'b0;
      phase_err_q <= 1'b0;
      trig_q <= 1'b0;
      trig_seen_q <= 1'b0;
      ffe_q <= 1'b0;
      iffe_q <= 1'b0;
      afault_q <= 1'b0;
      i2t_q <= 1'b0;
      ip_cnt_q <= '0;
    end else begin
      neg_lim_q <= neg_lim_d;
      pos_lim_q <= pos_lim_d;
      db_err_q <= db_err_d;
      abort_dec_q <= abort_dec_d;
      search_q <= search_d;
      stop_lim_q <= stop_lim_d;
      homing_q <= homing_d;
      home_done_q <= home_done_d;
      phase_err_q <= phase_err_d;
      trig_q <= trig_d;
      trig_seen_q <= trig_seen_d;
      ffe_q <= ffe_d;
      iffe_q <= iffe_d;
      afault_q <= afault_d;
      i2t_q <= i2t_d;
      ip_cnt_q <= ip_cnt_d;
    end
  end

  // word assembly; unlisted positions stay at the zero reset value
  logic [23:0] w1_q, w1_d, w2_q, w2_d;
  always_comb begin
    w1_d = mswr_pkg::WORD_RESET;
    w1_d[mswr_pkg::W1_ACTIVE] = cond.motor_activation_setting;
    w1_d[mswr_pkg::W1_NEG_LIM] = neg_lim_q;
    w1_d[mswr_pkg::W1_POS_LIM] = pos_lim_q;
    w1_d[mswr_pkg::W1_FOLLOW] = cond.position_following_setting;
    w1_d[mswr_pkg::W1_COMMUT] = cond.onboard_commutation_setting;
    w1_d[mswr_pkg::W1_OPEN] = cond.loop_open;
    w1_d[mswr_pkg::W1_DEF_MOVE] = cond.definite_move;
    w1_d[mswr_pkg::W1_INTEG] = cond.integrator_gating_setting;
    w1_d[mswr_pkg::W1_DWELL] = cond.dwell_active;
    w1_d[mswr_pkg::W1_DB_ERR] = db_err_q;
    w1_d[mswr_pkg::W1_VEL_ZERO] = !cond.loop_open && cond.cmd_vel_zero;
    w1_d[mswr_pkg::W1_ABORT_DEC] = abort_dec_q;
    w1_d[mswr_pkg::W1_BLK_REQ] = cond.block_request;
    w1_d[mswr_pkg::W1_SEARCH] = search_q;
    w1_d[9:0] = cond.block_pointer;
    w2_d = mswr_pkg::WORD_RESET;
    w2_d[mswr_pkg::W2_ASSIGNED] = cond.assigned;
    w2_d[mswr_pkg::W2_GROUP_LSB +: 3] = cond.group_minus_one;
    w2_d[mswr_pkg::W2_AMP_EN] = cond.amp_enabled;
    w2_d[mswr_pkg::W2_STOP_LIM] = stop_lim_q;
    w2_d[mswr_pkg::W2_HOME_DONE] = home_done_q;
    w2_d[mswr_pkg::W2_PHASE_ERR] = phase_err_q;
    w2_d[mswr_pkg::W2_TRIG_MOVE] = trig_q;
    w2_d[mswr_pkg::W2_INT_FFE] = iffe_q;
    w2_d[mswr_pkg::W2_I2T] = i2t_q;
    w2_d[mswr_pkg::W2_AMP_FAULT] = afault_q;
    w2_d[mswr_pkg::W2_FATAL_FE] = ffe_q;
    w2_d[mswr_pkg::W2_WARN_FE] = warn;
    w2_d[mswr_pkg::W2_IN_POS] = ip_cond && ip_ok;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      w1_q <= mswr_pkg::WORD_RESET;
      w2_q <= mswr_pkg::WORD_RESET;
    end else begin
      w1_q <= w1_d;
      w2_q <= w2_d;
    end
  end

  assign motor_status_word_one = w1_q;
  assign motor_status_word_two = w2_q;

  // reply path; the snapshot is taken once so a reply never tears
  mswr_hex_tx u_tx (
    .clock(clock),
    .srst(srst),
    .start(query && query_ready),
    .data({w1_q, w2_q}),
    .idle(query_ready),
    .tx_char(tx_char),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_accept;
    query && query_ready;
  endsequence
  sequence s_first_char(logic [3:0] n);
    tx_valid && (tx_char == mswr_pkg::mswr_hex(n));
  endsequence

  property p_first_char;
    logic [3:0] n;
    (s_accept, n = w1_q[23:20]) |=> s_first_char(n);
  endproperty
  a_first_char: assert property (p_first_char)
    else $error("first reply character is not word one bits 23-20");

  property p_active;
    cond.motor_activation_setting |=> motor_status_word_one[23];
  endproperty
  a_active: assert property (p_active)
    else $error("activation bit did not follow the setting");

  property p_neg_hold;
    !updating |=> (neg_lim_q == $past(neg_lim_q));
  endproperty
  a_neg_hold: assert property (p_neg_hold)
    else $error("negative limit bit changed while not updating");

  property p_pos_set;
    updating && (actual_pos > positive_soft_limit) |=> pos_lim_q ##1 motor_status_word_one[21];
  endproperty
  a_pos_set: assert property (p_pos_set)
    else $error("positive limit bit missing past soft limit");

  // a trigger that ends the previous homing move in the same cycle wins
  property p_home_clear;
    evt.homing_start && !(homing_q && evt.trigger_found) |=> !home_done_q;
  endproperty
  a_home_clear: assert property (p_home_clear)
    else $error("home complete not cleared at homing start");

  property p_int_fe;
    evt.int_fe_kill |=> ffe_q && iffe_q ##1 motor_status_word_two[1];
  endproperty
  a_int_fe: assert property (p_int_fe)
    else $error("integrated error kill did not set bits 6, 2 and 1");

  property p_fault_hold;
    afault_q && !evt.reenable |=> afault_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("amplifier fault latch dropped before re-enable");

  property p_db_err;
    evt.block_abort |=> db_err_q ##1 motor_status_word_one[14];
  endproperty
  a_db_err: assert property (p_db_err)
    else $error("data block error not flagged");

  property p_in_pos;
    motor_status_word_two[0] |-> $past(ip_cond) && $past(ip_cnt_q) != '0;
  endproperty
  a_in_pos: assert property (p_in_pos)
    else $error("in position without qualifying scans");

  property p_trig_stays;
    trig_q && evt.move_end && !trig_seen_q && !evt.trigger_found |=> trig_q;
  endproperty
  a_trig_stays: assert property (p_trig_stays)
    else $error("trigger move bit cleared without a trigger");
endmodule // mswr_top
`default_nettype wire

// File: logic/mswr_pkg.sv
// mswr_pkg: offsets, field positions, carrier structs and helpers for the status reporter
`default_nettype none
package mswr_pkg;
  // register locations of the two status words
  localparam logic [15:0] WORD_ONE_OFFSET = 16'h003D;
  localparam logic [15:0] WORD_TWO_OFFSET = 16'h0814;
  localparam logic [23:0] WORD_RESET = 24'h000000;
  // reply framing
  localparam int NIBBLES = 12;
  localparam logic [3:0] LAST_NIBBLE = 4'hB;
  // word one bit positions
  localparam int W1_ACTIVE = 23;
  localparam int W1_NEG_LIM = 22;
  localparam int W1_POS_LIM = 21;
  localparam int W1_FOLLOW = 20;
  localparam int W1_COMMUT = 19;
  localparam int W1_OPEN = 18;
  localparam int W1_DEF_MOVE = 17;
  localparam int W1_INTEG = 16;
  localparam int W1_DWELL = 15;
  localparam int W1_DB_ERR = 14;
  localparam int W1_VEL_ZERO = 13;
  localparam int W1_ABORT_DEC = 12;
  localparam int W1_BLK_REQ = 11;
  localparam int W1_SEARCH = 10;
  // word two bit positions
  localparam int W2_ASSIGNED = 23;
  localparam int W2_GROUP_LSB = 20;
  localparam int W2_AMP_EN = 14;
  localparam int W2_STOP_LIM = 11;
  localparam int W2_HOME_DONE = 10;
  localparam int W2_PHASE_ERR = 8;
  localparam int W2_TRIG_MOVE = 7;
  localparam int W2_INT_FFE = 6;
  localparam int W2_I2T = 5;
  localparam int W2_AMP_FAULT = 3;
  localparam int W2_FATAL_FE = 2;
  localparam int W2_WARN_FE = 1;
  localparam int W2_IN_POS = 0;

  // level conditions from servo, trajectory and setup logic
  typedef struct packed {
    logic motor_activation_setting;
    logic onboard_commutation_setting;
    logic position_following_setting;
    logic integrator_gating_setting;
    logic loop_open;
    logic amp_enabled;
    logic definite_move;
    logic dwell_active;
    logic cmd_vel_zero;
    logic timer_active;
    logic block_request;
    logic [9:0] block_pointer;
    logic assigned;
    logic [2:0] group_minus_one;
  } mswr_cond_t;

  // one-cycle event pulses
  typedef struct packed {
    logic block_abort;
    logic seq_start;
    logic abort_cmd;
    logic decel_done;
    logic search_start;
    logic homing_start;
    logic trigger_found;
    logic move_stopped;
    logic trig_move_start;
    logic move_end;
    logic limit_stop;
    logic phase_done;
    logic phase_fail;
    logic fatal_fe_kill;
    logic int_fe_kill;
    logic amp_fault_kill;
    logic integrated_current_fault;
    logic reenable;
    logic scan_tick;
  } mswr_evt_t;

  // nibble to ascii hexadecimal, upper case letters
  function automatic logic [7:0] mswr_hex(input logic [3:0] n);
    mswr_hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
endpackage
`default_nettype wire

// File: logic/mswr_hex_tx.sv
// mswr_hex_tx: sends a 48-bit snapshot as twelve ascii hex characters
`timescale 1ns/100ps
`default_nettype none
module mswr_hex_tx (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // snapshot side
  input wire logic start,
  input wire logic [47:0] data,
  output logic idle,
  // character stream
  output logic [7:0] tx_char,
  output logic tx_valid,
  input wire logic tx_ready
);
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} mswr_tx_state_t;
  mswr_tx_state_t state_q, state_d;
  logic [47:0] buf_q, buf_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] char_q, char_d;

  // next state: load on start, shift one nibble per accepted character
  always_comb begin
    state_d = state_q;
    buf_d = buf_q;
    idx_d = idx_q;
    char_d = char_q;
    unique case (state_q)
      TX_IDLE: begin
        if (start) begin
          state_d = TX_SEND;
          buf_d = data;
          idx_d = 4'h0;
          char_d = mswr_pkg::mswr_hex(data[47:44]);
        end
      end
      TX_SEND: begin
        if (tx_ready) begin
          if (idx_q == mswr_pkg::LAST_NIBBLE) begin
            state_d = TX_IDLE;
          end else begin
            buf_d = {buf_q[43:0], 4'h0};
            idx_d = idx_q + 4'h1;
            char_d = mswr_pkg::mswr_hex(buf_q[43:40]);
          end
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= TX_IDLE;
      buf_q <= 48'h000000000000;
      idx_q <= 4'h0;
      char_q <= 8'h00;
    end else begin
      state_q <= state_d;
      buf_q <= buf_d;
      idx_q <= idx_d;
      char_q <= char_d;
    end
  end

  assign idle = (state_q == TX_IDLE);
  assign tx_valid = (state_q == TX_SEND);
  assign tx_char = char_q;
endmodule // mswr_hex_tx
`default_nettype wire

// File: bench/mswr_host_model.sv
// mswr_host_model: host that asks for motor status and collects the reply characters
`timescale 1ns/100ps
`default_nettype none
module mswr_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bench control
  input wire logic go,
  input wire logic slow,
  output logic done,
  output logic [95:0] reply,
  // status port of the block
  output logic query,
  input wire logic query_ready,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [1:0] st;
  logic [3:0] n;
  // slow mode accepts every other cycle so each character has to stand
  always @(posedge clock) begin
    if (srst) begin
      st <= 2'h0;
      n <= 4'h0;
      query <= 1'h0;
      tx_ready <= 1'h0;
      done <= 1'h0;
      reply <= '0;
    end else begin
      tx_ready <= (st == 2'h2) && (!slow || !tx_ready);
      case (st)
        2'h0: if (go) begin
          query <= 1'h1;
          done <= 1'h0;
          n <= 4'h0;
          st <= 2'h1;
        end
        // request held until the block takes it
        2'h1: if (query_ready) begin
          query <= 1'h0;
          st <= 2'h2;
        end
        default: if (tx_valid && tx_ready) begin
          reply <= {reply[87:0], tx_char};
          n <= n + 4'h1;
          if (n == 4'hB) begin
            done <= 1'h1;
            st <= 2'h0;
          end
        end
      endcase
    end
  end
endmodule // mswr_host_model
`default_nettype wire

// File: bench/tb.sv
// tb: self-checking bench for the motor status word reporter
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock;
  logic srst;
  mswr_pkg::mswr_cond_t cond;
  mswr_pkg::mswr_evt_t evt;
  mswr_pkg::mswr_evt_t e;
  logic signed [23:0] actual_pos;
  logic signed [23:0] positive_soft_limit;
  logic signed [23:0] negative_soft_limit;
  logic [23:0] fe_mag;
  logic [23:0] warning_error_limit;
  logic [23:0] in_position_band;
  logic [7:0] in_position_scan_count;
  logic overtravel_input_a;
  logic overtravel_input_b;
  logic query;
  logic query_ready;
  logic [7:0] tx_char;
  logic tx_valid;
  logic tx_ready;
  logic [23:0] w1;
  logic [23:0] w2;
  logic host_go;
  logic host_slow;
  logic host_done;
  logic [95:0] reply;
  int error_cnt = 0;
  int check_count = 0;

  // block under test and the host on its status port
  mswr_top i_dut (.clock, .srst, .cond, .evt, .actual_pos, .positive_soft_limit,
    .negative_soft_limit, .fe_mag, .warning_error_limit, .in_position_band,
    .in_position_scan_count, .overtravel_input_a, .overtravel_input_b, .query,
    .query_ready, .tx_char, .tx_valid, .tx_ready, .motor_status_word_one(w1),
    .motor_status_word_two(w2));
  mswr_host_model i_host (.clock, .srst, .go(host_go), .slow(host_slow),
    .done(host_done), .reply, .query, .query_ready, .tx_char, .tx_valid, .tx_ready);

  // 250 MHz clock
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one-cycle event, then time for latch and word register
  task automatic fire(input mswr_pkg::mswr_evt_t v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= '0;
    tick(3);
  endtask

  // expected reply built bench-side, most significant nibble first
  function automatic logic [95:0] hex12(input logic [47:0] v);
    logic [3:0] d;
    for (int k = 0; k < 12; k++) begin
      d = v[47-4*k -: 4];
      hex12[95-8*k -: 8] = (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
    end
  endfunction

  // query with bounded wait; a hang ends the run
  task automatic ask(input logic slow, input logic [47:0] words);
    @(posedge clock);
    host_go <= 1'h1;
    host_slow <= slow;
    @(posedge clock);
    host_go <= 1'h0;
    // done of the previous reply drops only at this edge
    tick(1);
    for (int i = 0; i < 200 && host_done !== 1'h1; i++) tick(1);
    if (host_done !== 1'h1) begin
      error_cnt++;
      tally_and_finish();
    end
    chk(reply, hex12(words));
    tick(1);
    chk(query_ready, 1'h1);
  endtask

  task automatic t_reset;
    chk({w1, w2}, 48'h0);
    chk({query_ready, tx_valid}, 2'h2);
  endtask

  task automatic t_levels;
    // active, follow, commutate, integ gate, closed, amp on, move, dwell, vel zero, ptr 2A5, group 6
    @(posedge clock);
    cond <= {8'hF7, 2'h2, 1'h1, 10'h2A5, 1'h1, 3'h5};
    tick(3);
    chk(w1, 24'h9BAAA5);
    chk(w2, 24'hD04000);
    ask(1'h0, 48'h9BAAA5D04000);
    ask(1'h1, 48'h9BAAA5D04000);
    @(posedge clock);
    cond.loop_open <= 1'h1;
    tick(3);
    chk({w1[18], w1[13]}, 2'h2);
    @(posedge clock);
    cond.loop_open <= 1'h0;
    cond.cmd_vel_zero <= 1'h0;
    cond.motor_activation_setting <= 1'h0;
    tick(3);
    chk({w1[23], w1[18], w1[13]}, 3'h0);
    @(posedge clock);
    cond <= {8'h84, 2'h2, 11'h0, 1'h1, 3'h0};
    tick(3);
    chk(w1, 24'h802000);
  endtask

  task automatic t_limits;
    @(posedge clock);
    actual_pos <= 24'hFFF000;
    tick(3);
    chk(w1[22:21], 2'h2);
    @(posedge clock);
    actual_pos <= 24'h000400;
    tick(3);
    chk(w1[22:21], 2'h1);
    @(posedge clock);
    actual_pos <= 24'h000000;
    overtravel_input_a <= 1'h1;
    tick(5);
    chk(w1[22:21], 2'h2);
    @(posedge clock);
    overtravel_input_a <= 1'h0;
    cond.amp_enabled <= 1'h0;
    overtravel_input_b <= 1'h1;
    tick(5);
    chk({w1[22:21], w2[14]}, 3'h4);
    @(posedge clock);
    cond.amp_enabled <= 1'h1;
    tick(5);
    chk(w1[22:21], 2'h1);
    @(posedge clock);
    overtravel_input_b <= 1'h0;
    cond.motor_activation_setting <= 1'h0;
    tick(5);
    chk(w1[21], 1'h1);
    @(posedge clock);
    cond.motor_activation_setting <= 1'h1;
    tick(3);
    chk(w1[22:21], 2'h0);
  endtask

  task automatic t_events;
    e = '0;
    e.block_abort = 1'h1;
    e.limit_stop = 1'h1;
    fire(e);
    chk({w1[14], w1[12], w2[11]}, 3'h7);
    e = '0;
    e.decel_done = 1'h1;
    fire(e);
    chk({w1[14], w1[12], w2[11]}, 3'h5);
    e = '0;
    e.seq_start = 1'h1;
    fire(e);
    chk({w1[14], w2[11]}, 2'h0);
    e = '0;
    e.abort_cmd = 1'h1;
    e.homing_start = 1'h1;
    e.search_start = 1'h1;
    fire(e);
    chk({w1[12], w1[10], w2[10]}, 3'h6);
    e = '0;
    e.trigger_found = 1'h1;
    fire(e);
    chk({w1[10], w2[10]}, 2'h1);
    e = '0;
    e.homing_start = 1'h1;
    e.search_start = 1'h1;
    e.trig_move_start = 1'h1;
    fire(e);
    chk({w1[10], w2[10], w2[7]}, 3'h5);
    e = '0;
    e.move_stopped = 1'h1;
    e.move_end = 1'h1;
    fire(e);
    chk({w1[10], w2[10], w2[7]}, 3'h1);
    e = '0;
    e.trig_move_start = 1'h1;
    fire(e);
    e = '0;
    e.trigger_found = 1'h1;
    fire(e);
    e = '0;
    e.move_end = 1'h1;
    e.phase_done = 1'h1;
    e.phase_fail = 1'h1;
    fire(e);
    chk({w2[8], w2[7]}, 2'h2);
    e = '0;
    e.phase_done = 1'h1;
    e.integrated_current_fault = 1'h1;
    fire(e);
    chk(w2[8:0], 9'h028);
    e = '0;
    e.reenable = 1'h1;
    fire(e);
    e = '0;
    e.amp_fault_kill = 1'h1;
    e.int_fe_kill = 1'h1;
    fire(e);
    chk(w2[6:0], 7'h4E);
    e = '0;
    e.reenable = 1'h1;
    fire(e);
    chk(w2[6:0], 7'h00);
    @(posedge clock);
    fe_mag <= 24'h0000C8;
    tick(3);
    chk(w2[2:0], 3'h2);
    e = '0;
    e.fatal_fe_kill = 1'h1;
    fire(e);
    @(posedge clock);
    fe_mag <= 24'h000000;
    tick(3);
    chk(w2[6:0], 7'h06);
    e = '0;
    e.reenable = 1'h1;
    fire(e);
    chk(w2[2:0], 3'h0);
  endtask

  task automatic t_inpos;
    e = '0;
    e.scan_tick = 1'h1;
    fire(e);
    fire(e);
    chk(w2[0], 1'h0);
    fire(e);
    chk(w2[0], 1'h1);
    @(posedge clock);
    cond.timer_active <= 1'h1;
    tick(3);
    chk(w2[0], 1'h0);
    @(posedge clock);
    cond.timer_active <= 1'h0;
    tick(3);
    chk(w2[0], 1'h0);
  endtask

  // reset, then the scenarios in turn
  initial begin
    srst = 1'h1;
    cond = '0;
    evt = '0;
    actual_pos = '0;
    positive_soft_limit = 24'h0003E8;
    negative_soft_limit = 24'hFFFC18;
    fe_mag = '0;
    warning_error_limit = 24'h000064;
    in_position_band = 24'h00000A;
    in_position_scan_count = 8'h02;
    overtravel_input_a = 1'h0;
    overtravel_input_b = 1'h0;
    host_go = 1'h0;
    host_slow = 1'h0;
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    tick(1);
    t_reset();
    t_levels();
    t_limits();
    t_events();
    t_inpos();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
